// *** bench/head_model.sv ***
`timescale 1ns/1ns
module head_model (
	input  wire logic        clk_sys,
	input  wire logic        headOpReq,
	input  wire logic        headOpWrite,
	input  wire logic [15:0] headAddr,
	input  wire logic [7:0]  headWrData,
	input  wire logic        corrupt,
	output logic             headAck,
	output logic [7:0]       headRdData
);
	logic [7:0] mem [0:255];
	logic       wait_reg;
	logic       opNow;
	////////////////////////////////////////////////////////////////////////
	// Idle cycle before each ack; registered address settles meanwhile
	assign opNow = headOpReq && !headAck && wait_reg;
	always_ff @(posedge clk_sys) begin
		wait_reg <= headOpReq && !headAck && !wait_reg;
		headAck  <= opNow;
		if (opNow && headOpWrite)
			mem[headAddr[7:0]] <= headWrData;
		// Read bus toggles when no byte is offered
		headRdData <= (opNow && !headOpWrite)
			? mem[headAddr[7:0]] ^ {7'h00, corrupt} : ~headRdData;
	end
endmodule : head_model

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
	import rfid_vwc_pkg::*;
	logic        clk_sys, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, headOpReq;
	logic        headOpWrite, headAck, headTagPresent, headExec, headBusAll;
	logic        headResValid, corrupt;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, headWrData, headRdData;
	logic [31:0] s_axi_wdata, s_axi_rdata, headResData, s;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] headAddr;
	logic [2:0]  headContCmd;
	logic [3:0]  s_axi_wstrb;
	int          errCount, compares, execs;
	rfid_verify_write_continuous_cmd i_rfid_verify_write_continuous_cmd (
		.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .headOpReq, .headOpWrite, .headAddr, .headWrData,
		.headAck, .headRdData, .headTagPresent, .headExec, .headBusAll,
		.headContCmd, .headResValid, .headResData);
	head_model i_head_model (.clk_sys, .headOpReq, .headOpWrite, .headAddr,
		.headWrData, .corrupt, .headAck, .headRdData);
	////////////////////////////////////////////////////////////////////////
	// Clock and pulse counter
	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (headExec === 1'b1) execs++;
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, errCount);
		if (errCount == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errCount++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic hang;
		errCount++;
		complete_run();
	endtask : hang
	////////////////////////////////////////////////////////////////////////
	// Bus master: each channel released at its own handshake
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 0;
		if (n == 50) hang();
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		s_axi_rready <= 0;
		if (n == 50) hang();
	endtask : axr
	////////////////////////////////////////////////////////////////////////
	// Verified write of len random bytes; progress sampled while busy
	task automatic verify(input logic [15:0] code, input logic bad,
		input int len, input logic [7:0] uid, input logic frag);
		logic [31:0] p;
		int i;
		logic mid;
		mid = 0;
		corrupt <= bad;
		axw(OFF_PARAM, {15'h0000, frag, 8'(len), uid});
		for (i = 0; i < len + uid; i++) axw(OFF_WDATA, $urandom & 32'hFF);
		axw(OFF_CMD, {16'h0000, code});
		for (i = 0; i < 80; i++) begin
			axr(OFF_PROG, p);
			if (p[7:0] > 0 && p[7:0] < len) mid = 1;
			axr(OFF_STATUS, s);
			if (!s[25]) break;
		end
		if (i == 80) hang();
		chk(s[15:0], 16'h0008);
		chk(s[23:16], bad ? ERR_VERIFY : ERR_NONE);
		axr(OFF_PROG, p);
		chk(p[23:16], 0);
		chk(p[15:8], frag);
		chk(p[7:0], len);
		chk(mid, 1);
		$display("verify %h done", code);
	endtask : verify
	// Expected start answer from the mode rules
	function automatic logic [7:0] contErr(input logic [31:0] c);
		return ((c[1] && !c[0]) || c[2] || c[6:4] > CONT_INFO
			|| (c[0] && c[6:4] == CONT_INFO)) ? ERR_REJECT : ERR_NONE;
	endfunction : contErr
	task automatic cont(input logic [31:0] cfg);
		axw(OFF_CONFIG, cfg);
		axw(OFF_CMD, {16'h0000, CODE_CONT});
		axr(OFF_STATUS, s);
		chk(s[23:16], contErr(cfg));
		chk(s[26], contErr(cfg) == ERR_NONE);
		$display("continuous start %h done", cfg);
	endtask : cont
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] first;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, headTagPresent, headResValid, corrupt} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, headResData} = 0;
		s_axi_wstrb = 4'hF;
		errCount = 0;
		compares = 0;
		execs = 0;
		reset_n = 0;
		void'($urandom(41));
		repeat (20) @(posedge clk_sys);
		reset_n <= 1;
		verify(CODE_VERIFY, 0, 10, 8'h00, 0);
		verify(CODE_VERIFY_FAST, 1, 4 + $urandom % 9, 8'h03, 1);
		cont(32'h0000_0012);
		cont(32'h0000_0014);
		cont(32'h0000_0031);
		axw(OFF_START, 32'h0000_0003);
		headTagPresent <= 1;
		cont(32'h0000_0010);
		chk(headContCmd, CONT_READ);
		chk(execs, 0);
		headTagPresent <= 0;
		repeat (3) @(posedge clk_sys);
		headTagPresent <= 1;
		repeat (3) @(posedge clk_sys);
		chk(execs, 1);
		axr(OFF_STATUS, s);
		chk(s[24], 1);
		for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
			headResValid <= 1;
			headResData <= $urandom;
			@(posedge clk_sys);
			if (k == 0) first = headResData;
			headResValid <= 0;
			@(posedge clk_sys);
		end
		axr(OFF_STATUS, s);
		chk({s[27], s[23:16]}, {1'b1, ERR_OVFL});
		axr(OFF_FIFO, s);
		chk(s, first);
		cont(32'h0000_0010);
		axr(OFF_LEVEL, s);
		chk(s, 0);
		headResValid <= 1;
		@(posedge clk_sys);
		headResValid <= 0;
		axw(OFF_CMD, {16'h0000, CODE_RESET});
		axr(OFF_STATUS, s);
		chk(s[26], 0);
		axr(OFF_LEVEL, s);
		chk(s, 0);
		cont(32'h0000_0008);
		chk({headBusAll, headContCmd}, {1'b1, CONT_INV});
		headTagPresent <= 0;
		repeat (3) @(posedge clk_sys);
		axr(OFF_STATUS, s);
		chk(s[24], 1);
		axw(OFF_CMD, {16'h0000, CODE_RESET});
		cont(32'h0000_0011);
		headTagPresent <= 1;
		repeat (3) @(posedge clk_sys);
		axr(OFF_STATUS, s);
		chk(s[24], 0);
		$display("continuous tests done");
		complete_run();
	end
endmodule : testbench

// *** hw/axil_reg_port.sv ***
`timescale 1ns/1ns
module axil_reg_port (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wrStb,
	output logic [7:0]       wrAddr,
	output logic [31:0]      wrData,
	output logic [3:0]       wrStrb,
	input  wire logic        wrOk,
	output logic             rdStb,
	output logic [7:0]       rdAddr,
	input  wire logic [31:0] rdData,
	input  wire logic        rdOk
);
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	assign wrStb  = s_axi_awready && s_axi_awvalid;
	assign wrAddr = s_axi_awaddr;
	assign wrData = s_axi_wdata;
	assign wrStrb = s_axi_wstrb;
	assign rdStb  = s_axi_arready && s_axi_arvalid;
	assign rdAddr = s_axi_araddr;

	// Write: both channels taken together, one cycle later response
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
				&& !s_axi_awready;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
				&& !s_axi_awready;
			if (wrStb) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read: data captured at the address handshake
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
			if (rdStb) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdData;
				s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule : axil_reg_port

// *** hw/rfid_result_fifo.sv ***
`timescale 1ns/1ns
module rfid_result_fifo
	import rfid_vwc_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	input  wire logic                    clear,
	input  wire logic                    inValid,
	output logic                         inReady,
	input  wire logic [FIFO_WIDTH-1:0]   inData,
	output logic                         outValid,
	input  wire logic                    outReady,
	output logic [FIFO_WIDTH-1:0]        outData,
	output logic [FIFO_AW:0]             level
);
	logic [FIFO_WIDTH-1:0] mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0]    wrPtr_reg;
	logic [FIFO_AW-1:0]    rdPtr_reg;
	logic [FIFO_AW:0]      count_reg;
	logic                  push;
	logic                  pop;

	// Full refuses, empty answers not valid
	assign inReady  = (count_reg != FIFO_DEPTH[FIFO_AW:0]);
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign level    = count_reg;
	assign push     = inValid && inReady && !clear;
	assign pop      = outValid && outReady && !clear;

	// Storage has no reset; pointers guard it
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wrPtr_reg] <= inData;
	end

	// Pointers and fill count
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else if (clear) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (pop)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule : rfid_result_fifo

// *** hw/rfid_verify_write_continuous_cmd.sv ***
// Notes on behaviour
// (R1) Verify-write codes 0x0008 and fast 0x2008; response echoes code 8.
// (R2) Written bytes are read back and compared; mismatch gives an error code.
// (R3) Write-fragment 1 means fragmented transfer, 0 a single transfer.
// (R4) Controller puts UID/EPC first in write data; payload follows to 127.
// (R5) Bytes-available grows while the verified write runs.
// (R6) Verify response carries code 8 and read-fragment number zero.
// (R7) HF continuous mode refused when multitag handling is selected.
// (R8) Controller picks a fixed tag type; no auto-detect with continuous mode.
// (R9) Stored command runs by itself on each tag entering the field.
// (R10) In HF bus mode all active heads run the command together.
// (R11) Stored command: HF write/read/inventory/tag-info; UHF no tag-info.
// (R12) Continuous mode runs until stopped; reset command stops it.
// (R13) Reset command discards all read data held for the controller.
// (R14) Restart of continuous mode deletes the earlier session's results.
// (R15) Head results queue in the FIFO until the controller reads them.
// (R16) Tag already present at start is skipped; wait for next tag.
// (R17) HF continuous: tag-present updated only when start address is 3.
// (R18) HF bus continuous: tag-present updated only for start address 0 or 1.
// (R19) UHF continuous: tag-present never updated.
// (R20) UHF continuous parameters are set in the reader, not here.
// (R21) Full FIFO keeps entries and flags an overflow error.
`timescale 1ns/1ns
module rfid_verify_write_continuous_cmd
	import rfid_vwc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             headOpReq,
	output logic             headOpWrite,
	output logic [15:0]      headAddr,
	output logic [7:0]       headWrData,
	input  wire logic        headAck,
	input  wire logic [7:0]  headRdData,
	input  wire logic        headTagPresent,
	output logic             headExec,
	output logic             headBusAll,
	output logic [2:0]       headContCmd,
	input  wire logic        headResValid,
	input  wire logic [31:0] headResData
);
	logic        wrStb, rdStb, wrOk, rdOk;
	logic [7:0]  wrAddr, rdAddr;
	logic [31:0] wrData, rdData;
	logic [3:0]  wrStrb;
	logic [7:0]  wbuf [BUF_BYTES];
	logic [6:0]  winPtr_reg;
	logic [31:0] param_reg, config_reg;
	logic [15:0] start_reg, respCode_reg, fragOfs_reg;
	logic [7:0]  errCode_reg, bytesAvail_reg, idx_reg, fragNo_reg;
	logic        tagInRange_reg, contRunning_reg, tagPrev_reg, overflow_reg;
	logic        mismatch_reg, headOpReq_reg, headOpWrite_reg, headExec_reg;
	logic [15:0] headAddr_reg;
	logic [7:0]  headWrData_reg;
	logic        headBusAll_reg;
	vstate_t     vState_reg;
	logic        cmdStb, isVerify, contStart, resetCmd, contBad, fifoClear;
	logic        fifoReady, fifoValid, fifoPop;
	logic [31:0] fifoData;
	logic [FIFO_AW:0] fifoLevel;
	logic [7:0]  uidLen, payLen, bufIdx;
	logic        uhf, multi, autoType, busMode, tagRise, tagUpdOk;
	logic [2:0]  contSel;

	//////////////////////////////////////////////////////////////////////
	// Bus slave and register decode

	axil_reg_port u_bus (
		.clk_sys       (clk_sys),
		.reset_n       (reset_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wrStb         (wrStb),
		.wrAddr        (wrAddr),
		.wrData        (wrData),
		.wrStrb        (wrStrb),
		.wrOk          (wrOk),
		.rdStb         (rdStb),
		.rdAddr        (rdAddr),
		.rdData        (rdData),
		.rdOk          (rdOk)
	);

	// Address decode shared by both directions
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= OFF_START) && (a[1:0] == 2'b00);
	endfunction : mapped

	assign wrOk = mapped(wrAddr);
	assign rdOk = mapped(rdAddr);

	// Read mux; FIFO read pops one result
	always_comb begin
		rdData = 32'h0000_0000;
		case (rdAddr)
			OFF_PARAM:  rdData = param_reg;
			OFF_CONFIG: rdData = config_reg;
			OFF_START:  rdData = {16'h0000, start_reg};
			OFF_STATUS: rdData = {4'h0, overflow_reg, contRunning_reg,
				(vState_reg != V_IDLE), tagInRange_reg, errCode_reg,
				respCode_reg};
			OFF_PROG:   rdData = {16'h0000, fragNo_reg, bytesAvail_reg}; // [R6]
			OFF_FIFO:   rdData = fifoValid ? fifoData : 32'h0000_0000;
			OFF_LEVEL:  rdData = {{(31-FIFO_AW){1'b0}}, fifoLevel};
			default:    rdData = 32'h0000_0000;
		endcase
	end
	assign fifoPop = rdStb && (rdAddr == OFF_FIFO); // [R15]

	// Field views
	assign uidLen   = param_reg[7:0];
	assign payLen   = param_reg[PARAM_LEN_LSB +: 8];
	assign uhf      = config_reg[CFG_UHF];
	assign multi    = config_reg[CFG_MULTI];
	assign autoType = config_reg[CFG_AUTO];
	assign busMode  = config_reg[CFG_BUS];
	assign contSel  = config_reg[CFG_CMD_LSB +: 3];
	assign bufIdx   = (9'(uidLen) + 9'(idx_reg) > 9'(LAST_BYTE)) ? LAST_BYTE
		: 8'(uidLen + idx_reg); // [R4]

	// Command decode
	assign cmdStb    = wrStb && (wrAddr == OFF_CMD);
	assign isVerify  = (wrData[15:0] == CODE_VERIFY)
		|| (wrData[15:0] == CODE_VERIFY_FAST); // [R1]
	assign resetCmd  = cmdStb && (wrData[15:0] == CODE_RESET);
	assign contBad   = (!uhf && multi) || autoType // [R7] [R8]
		|| (contSel > CONT_INFO)
		|| (uhf && contSel == CONT_INFO); // [R11]
	assign contStart = cmdStb && (wrData[15:0] == CODE_CONT) && !contBad
		&& (vState_reg == V_IDLE);
	assign fifoClear = resetCmd || contStart; // [R13] [R14]

	// Parameter registers; frozen while continuous mode runs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			param_reg  <= 32'h0000_0000;
			config_reg <= 32'h0000_0000;
			start_reg  <= 16'h0000;
		end else if (wrStb && !contRunning_reg) begin
			if (wrAddr == OFF_PARAM)
				param_reg <= wrData;
			if (wrAddr == OFF_CONFIG)
				config_reg <= wrData;
			if (wrAddr == OFF_START)
				start_reg <= wrData[15:0];
		end
	end

	// Write-data window, pointer rewinds at each command
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			winPtr_reg <= 7'h00;
		else if (cmdStb)
			winPtr_reg <= 7'h00;
		else if (wrStb && wrAddr == OFF_WDATA)
			winPtr_reg <= winPtr_reg + 7'h01;
	end
	always_ff @(posedge clk_sys) begin
		if (wrStb && wrAddr == OFF_WDATA && wrStrb[0])
			wbuf[winPtr_reg] <= wrData[7:0];
	end

	//////////////////////////////////////////////////////////////////////
	// Verified write sequencer

	// Write all payload bytes, then read back and compare
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vState_reg      <= V_IDLE;
			idx_reg         <= 8'h00;
			mismatch_reg    <= 1'b0;
			headOpReq_reg   <= 1'b0;
			headOpWrite_reg <= 1'b0;
		end else begin
			case (vState_reg)
				V_IDLE: begin
					if (cmdStb && isVerify && !contRunning_reg) begin
						idx_reg      <= 8'h00;
						mismatch_reg <= 1'b0;
						vState_reg   <= (payLen == 8'h00) ? V_FIN : V_WRITE;
						headOpReq_reg   <= (payLen != 8'h00);
						headOpWrite_reg <= 1'b1;
					end
				end
				V_WRITE: begin
					if (headAck) begin
						if (idx_reg + 8'h01 == payLen) begin
							idx_reg         <= 8'h00;
							headOpWrite_reg <= 1'b0;
							vState_reg      <= V_READ; // [R2]
						end else
							idx_reg <= idx_reg + 8'h01;
					end
				end
				V_READ: begin
					if (headAck) begin
						if (headRdData != wbuf[bufIdx[6:0]])
							mismatch_reg <= 1'b1; // [R2]
						if (idx_reg + 8'h01 == payLen) begin
							headOpReq_reg <= 1'b0;
							vState_reg    <= V_FIN;
						end else
							idx_reg <= idx_reg + 8'h01;
					end
				end
				V_FIN: vState_reg <= V_IDLE;
				default: vState_reg <= V_IDLE;
			endcase
		end
	end

	// Head address and write byte track the index
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			headAddr_reg   <= 16'h0000;
			headWrData_reg <= 8'h00;
		end else begin
			headAddr_reg   <= start_reg + fragOfs_reg + {8'h00, idx_reg};
			headWrData_reg <= wbuf[bufIdx[6:0]];
		end
	end

	// Fragment offset: fragmented transfers append, single restarts
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fragOfs_reg <= 16'h0000;
			fragNo_reg  <= 8'h00;
		end else if (vState_reg == V_FIN) begin
			if (param_reg[PARAM_FRAG]) begin // [R3]
				fragOfs_reg <= fragOfs_reg + {8'h00, payLen};
				fragNo_reg  <= fragNo_reg + 8'h01;
			end else begin
				fragOfs_reg <= 16'h0000;
				fragNo_reg  <= 8'h00;
			end
		end
	end

	// Progress grows per written byte, not only at the end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			bytesAvail_reg <= 8'h00;
		else if (vState_reg == V_IDLE && cmdStb && isVerify)
			bytesAvail_reg <= 8'h00;
		else if (vState_reg == V_WRITE && headAck)
			bytesAvail_reg <= bytesAvail_reg + 8'h01; // [R5]
	end

	// Response code and error code
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			respCode_reg <= 16'h0000;
			errCode_reg  <= ERR_NONE;
		end else if (vState_reg == V_FIN) begin
			respCode_reg <= CODE_VERIFY; // [R1] [R6]
			errCode_reg  <= mismatch_reg ? ERR_VERIFY : ERR_NONE;
		end else if (cmdStb && !isVerify) begin
			respCode_reg <= wrData[15:0];
			errCode_reg  <= (resetCmd || contStart) ? ERR_NONE
				: (wrData[15:0] == CODE_CONT) ? ERR_REJECT : ERR_BUSY;
		end else if (cmdStb && (vState_reg != V_IDLE || contRunning_reg))
			errCode_reg <= ERR_BUSY;
		else if (overflow_reg)
			errCode_reg <= ERR_OVFL; // [R21]
	end

	//////////////////////////////////////////////////////////////////////
	// Continuous mode

	assign tagRise = headTagPresent && !tagPrev_reg;

	// Run flag; reset command is the only stop
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			contRunning_reg <= 1'b0;
		else if (resetCmd)
			contRunning_reg <= 1'b0; // [R12]
		else if (contStart)
			contRunning_reg <= 1'b1;
	end

	// Edge register follows the tag every cycle, so a resident tag is skipped
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tagPrev_reg    <= 1'b0;
			headExec_reg   <= 1'b0;
			headBusAll_reg <= 1'b0;
		end else begin
			tagPrev_reg    <= headTagPresent; // [R16]
			headExec_reg   <= contRunning_reg && !contStart && tagRise; // [R9]
			headBusAll_reg <= contRunning_reg && busMode && !uhf; // [R10]
		end
	end

	// Tag-present indication gated by mode and start address
	assign tagUpdOk = !contRunning_reg ? 1'b1
		: uhf ? 1'b0 // [R19]
		: busMode ? (start_reg == SA_BUS_0 || start_reg == SA_BUS_1) // [R18]
		: (start_reg == SA_HF_CONT); // [R17]
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			tagInRange_reg <= 1'b0;
		else if (tagUpdOk)
			tagInRange_reg <= headTagPresent;
	end

	// Sticky overflow; a new overflow beats the clear
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			overflow_reg <= 1'b0;
		else if (headResValid && !fifoReady && contRunning_reg)
			overflow_reg <= 1'b1; // [R21]
		else if (fifoClear)
			overflow_reg <= 1'b0;
	end

	// Results held until the controller reads them
	rfid_result_fifo u_fifo (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.clear    (fifoClear),
		.inValid  (headResValid && contRunning_reg), // [R15]
		.inReady  (fifoReady),
		.inData   (headResData),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData),
		.level    (fifoLevel)
	);

	assign headOpReq   = headOpReq_reg;
	assign headOpWrite = headOpWrite_reg;
	assign headAddr    = headAddr_reg;
	assign headWrData  = headWrData_reg;
	assign headExec    = headExec_reg;
	assign headBusAll  = headBusAll_reg;
	assign headContCmd = config_reg[CFG_CMD_LSB +: 3];

	//////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_lastRead;
		(vState_reg == V_READ) && headAck && (idx_reg + 8'h01 == payLen);
	endsequence
	property p_echoCode;
		s_lastRead ##1 (vState_reg == V_FIN) |=> (respCode_reg == CODE_VERIFY);
	endproperty
	a_echoCode: assert property (p_echoCode) else $error("bad echo"); // [R1]
	property p_readFrag;
		(rdStb && rdAddr == OFF_PROG) |=> (s_axi_rdata[23:16] == 8'h00);
	endproperty
	a_readFrag: assert property (p_readFrag) else $error("rd frag"); // [R6]
	property p_progress;
		(vState_reg == V_WRITE && headAck)
			|=> (bytesAvail_reg == $past(bytesAvail_reg) + 8'h01);
	endproperty
	a_progress: assert property (p_progress) else $error("no growth"); // [R5]
	property p_mismatch;
		(vState_reg == V_READ && headAck && headRdData != wbuf[bufIdx[6:0]])
			|=> mismatch_reg ##[1:300] (errCode_reg == ERR_VERIFY);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("miss lost"); // [R2]
	property p_multiReject;
		(cmdStb && wrData[15:0] == CODE_CONT && !uhf && multi
			&& !contRunning_reg) |=> !contRunning_reg;
	endproperty
	a_multiReject: assert property (p_multiReject) else $error("multi"); // [R7]
	property p_exec;
		(contRunning_reg && !contStart && tagRise) |=> headExec;
	endproperty
	a_exec: assert property (p_exec) else $error("no exec"); // [R9]
	property p_skipResident;
		(contStart && headTagPresent) ##1 headTagPresent |=> !headExec;
	endproperty
	a_skipResident: assert property (p_skipResident) else $error("rsdt"); // [R16]
	property p_resetStops;
		resetCmd |=> !contRunning_reg && (fifoLevel == '0);
	endproperty
	a_resetStops: assert property (p_resetStops) else $error("rst"); // [R12]
	property p_overflow;
		(headResValid && contRunning_reg && !fifoReady
			&& !fifoPop && !fifoClear)
			|=> overflow_reg && $stable(fifoLevel);
	endproperty
	a_overflow: assert property (p_overflow) else $error("ovfl"); // [R21]
	property p_uhfHold;
		(contRunning_reg && uhf) |=> $stable(tagInRange_reg);
	endproperty
	a_uhfHold: assert property (p_uhfHold) else $error("uhf tag"); // [R19]
endmodule : rfid_verify_write_continuous_cmd

// *** hw/rfid_vwc_pkg.sv ***
package rfid_vwc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_PARAM  = 8'h04;
	localparam logic [7:0] OFF_CONFIG = 8'h08;
	localparam logic [7:0] OFF_WDATA  = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_PROG   = 8'h14;
	localparam logic [7:0] OFF_FIFO   = 8'h18;
	localparam logic [7:0] OFF_LEVEL  = 8'h1C;
	localparam logic [7:0] OFF_START  = 8'h20;

	// Command codes
	localparam logic [15:0] CODE_VERIFY      = 16'h0008;
	localparam logic [15:0] CODE_VERIFY_FAST = 16'h2008;
	localparam logic [15:0] CODE_CONT        = 16'h0010;
	localparam logic [15:0] CODE_RESET       = 16'h0041;

	// Error codes
	localparam logic [7:0] ERR_NONE   = 8'h00;
	localparam logic [7:0] ERR_VERIFY = 8'h01;
	localparam logic [7:0] ERR_REJECT = 8'h02;
	localparam logic [7:0] ERR_BUSY   = 8'h03;
	localparam logic [7:0] ERR_OVFL   = 8'h04;

	// Stored continuous command selector
	localparam logic [2:0] CONT_INV  = 3'h0;
	localparam logic [2:0] CONT_READ = 3'h1;
	localparam logic [2:0] CONT_WR   = 3'h2;
	localparam logic [2:0] CONT_INFO = 3'h3;

	// Start-address values enabling tag-present updates
	localparam logic [15:0] SA_HF_CONT = 16'h0003;
	localparam logic [15:0] SA_BUS_0   = 16'h0000;
	localparam logic [15:0] SA_BUS_1   = 16'h0001;

	// Field positions
	localparam int PARAM_LEN_LSB = 8;
	localparam int PARAM_FRAG    = 16;
	localparam int CFG_UHF       = 0;
	localparam int CFG_MULTI     = 1;
	localparam int CFG_AUTO      = 2;
	localparam int CFG_BUS       = 3;
	localparam int CFG_CMD_LSB   = 4;

	// Sizes
	localparam int BUF_BYTES  = 128;
	localparam logic [7:0] LAST_BYTE = 8'h7F;
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW    = 4;

	typedef enum logic [1:0] {
		V_IDLE  = 2'b00,
		V_WRITE = 2'b01,
		V_READ  = 2'b11,
		V_FIN   = 2'b10
	} vstate_t;
endpackage : rfid_vwc_pkg
